// ==== core/lmb_exec.sv ====
// Execution unit for logic, shift, move, bit and branch target operations.
//
// Overview of operation
// [RULE_01] AND, OR and XOR on bytes or words update zero and negative flags.
// [RULE_02] Left shift moves bits toward the top and loads 0 at bit 0.
// [RULE_03] Right shifts load 0 at the top, or keep the top bit (arithmetic).
// [RULE_04] Plain move copies a byte, word or dword between any places; the code writes register targets only, memory gets no write strobe.
// [RULE_05] External move uses the extension byte as region; it resets to 01H.
// [RULE_06] Code move reads one byte from code region FF into the accumulator.
// [RULE_07] Extending moves fill the high byte with sign copies or zeros.
// [RULE_08] High word move writes 16 immediate bits into a dword's upper word.
// [RULE_09] Nibble exchange swaps low nibbles of accumulator and a RAM byte.
// [RULE_10] Push takes byte, word or dword; pop returns byte or word, LIFO.
// [RULE_11] Bit set, clear and complement act on any addressable bit.
// [RULE_12] Bit AND and OR combine carry with the bit or its inverse.
// [RULE_13] Bit move copies a bit into carry, or carry into a bit.
// [RULE_14] Extended bits reach RAM 20H-7FH and all SFRs; legacy much less.
// [RULE_15] Only legacy bits may use a flat number; SFR number is addr plus pos.
// [RULE_16] The program counter is 24 bits wide.
// [RULE_17] Relative targets add a signed 8-bit offset to the next address.
// [RULE_18] An 11-bit target replaces only the low 11 counter bits.
// [RULE_19] A 16-bit target replaces only the low 16 counter bits.
// [RULE_20] A 24-bit target loads every counter bit.
// [RULE_21] Word register jumps load 16 low bits, keep the next address top.
// [RULE_22] Accumulator plus pointer jump puts the sum low, FF on top.
// [RULE_23] All three shifts leave the last bit shifted out in carry.
// [RULE_24] Zero flag means all-zero result; negative copies the result top.
`timescale 1ns/1ps
`include "lmb_params.svh"

module lmb_exec (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic op_valid_i,
  input wire lmb_pkg::lmb_op_t op_i,
  input wire lmb_pkg::lmb_size_t size_i,
  input wire logic [31:0] opa_i,
  input wire logic [31:0] opb_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic carry_flag_i,
  input wire logic [23:0] pc_next_i,
  input wire logic bit_legacy_i,
  input wire logic bit_flat_i,
  input wire logic [7:0] legacy_bit_operand_i,
  input wire logic bit_sfr_i,
  input wire logic [7:0] bit_reg_i,
  input wire logic [2:0] bit_pos_i,
  input wire logic [7:0] bit_byte_i,
  input wire logic bit_inv_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [31:0] result_o,
  output logic result_we_o,
  output logic [31:0] mem_wdata_o,
  output logic [23:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [1:0] mem_size_o,
  output logic bit_sfr_o,
  output logic zero_flag_o,
  output logic neg_flag_o,
  output logic zn_upd_o,
  output logic carry_flag_o,
  output logic carry_upd_o,
  output logic op_err_o,
  output logic [23:0] pc_o,
  output logic pc_load_o
);
  import lmb_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [31:0] size_mask(input lmb_size_t sz);
    case (sz)
      SZ_BYTE: size_mask = 32'h0000_00FF;
      SZ_WORD: size_mask = 32'h0000_FFFF;
      default: size_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic top_bit(input logic [31:0] v, input lmb_size_t sz);
    case (sz)
      SZ_BYTE: top_bit = v[7];
      SZ_WORD: top_bit = v[15];
      default: top_bit = v[31];
    endcase
  endfunction

  function automatic logic [23:0] size_bytes(input lmb_size_t sz);
    case (sz)
      SZ_BYTE: size_bytes = 24'h000001;
      SZ_WORD: size_bytes = 24'h000002;
      default: size_bytes = 24'h000004;
    endcase
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // Software visible state
  // ****************************************
  logic [7:0] dpx_ff;
  logic [23:0] sp_ff;
  logic [23:0] nxt_sp;
  logic [23:0] push_addr;
  logic [23:0] pop_addr;

  assign push_addr = sp_ff + 24'h000001;
  assign pop_addr = sp_ff - size_bytes(size_i) + 24'h000001;

  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      dpx_ff <= `LMB_DPX_RST; // RULE_05
    end else if (reg_wr_i && reg_addr_i == `LMB_REG_DPX_OFF) begin
      dpx_ff <= reg_wdata_i[7:0];
    end
  end

  // The stack grows upward; a pop reads the last bytes pushed.
  always_comb begin
    nxt_sp = sp_ff;
    if (op_valid_i && op_i == OP_PUSH) begin
      nxt_sp = sp_ff + size_bytes(size_i); // RULE_10
    end else if (op_valid_i && op_i == OP_POP && size_i != SZ_DWORD) begin
      nxt_sp = sp_ff - size_bytes(size_i); // RULE_10
    end
  end

  // A software write to the pointer wins over a stack operation in the
  // same cycle, so firmware can always re-seat the stack.
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sp_ff <= `LMB_SP_RST;
    end else if (reg_wr_i && reg_addr_i == `LMB_REG_SP_OFF) begin
      sp_ff <= reg_wdata_i[23:0];
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `LMB_REG_DPX_OFF: reg_rdata_o <= {24'h000000, dpx_ff};
        `LMB_REG_SP_OFF: reg_rdata_o <= {8'h00, sp_ff};
        `LMB_REG_STAT_OFF: reg_rdata_o <= {28'h0000000, op_err_o,
          carry_flag_o, neg_flag_o, zero_flag_o};
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Bit location
  // ****************************************
  logic loc_sfr;
  logic [7:0] loc_byte;
  logic [2:0] loc_pos;
  logic loc_ok;
  logic cur_bit;
  logic [7:0] bit_mask;

  always_comb begin
    loc_sfr = bit_sfr_i;
    loc_byte = bit_reg_i;
    loc_pos = bit_pos_i;
    loc_ok = 1'b1;
    if (bit_flat_i) begin
      // A flat number is legal only for legacy bits.
      loc_ok = bit_legacy_i; // RULE_15
      loc_pos = legacy_bit_operand_i[2:0];
      if (legacy_bit_operand_i[7]) begin
        loc_sfr = 1'b1;
        loc_byte = {legacy_bit_operand_i[7:3], 3'h0}; // RULE_15
      end else begin
        loc_sfr = 1'b0;
        loc_byte = `LMB_RAM_BIT_LO + {4'h0, legacy_bit_operand_i[6:3]};
      end
    end
    if (loc_sfr) begin
      if (loc_byte < `LMB_SFR_BASE) begin
        loc_ok = 1'b0;
      end else if (bit_legacy_i && loc_byte[2:0] != 3'h0) begin
        loc_ok = 1'b0; // RULE_14
      end
    end else if (loc_byte < `LMB_RAM_BIT_LO) begin
      loc_ok = 1'b0;
    end else if (bit_legacy_i && loc_byte > `LMB_RAM_BIT_HI_LEG) begin
      loc_ok = 1'b0; // RULE_14
    end else if (loc_byte > `LMB_RAM_BIT_HI_EXT) begin
      loc_ok = 1'b0; // RULE_14
    end
    bit_mask = 8'h01 << loc_pos;
    cur_bit = bit_byte_i[loc_pos];
  end

  // ****************************************
  // Operation results
  // ****************************************
  logic [31:0] nxt_result;
  logic nxt_result_we;
  logic [31:0] nxt_wdata;
  logic [23:0] nxt_addr;
  logic nxt_rd;
  logic nxt_wr;
  logic nxt_zn_upd;
  logic nxt_carry;
  logic nxt_carry_upd;
  logic nxt_err;
  logic [23:0] nxt_pc;
  logic nxt_pc_load;
  logic [31:0] mask;
  logic [15:0] jump_sum;

  assign mask = size_mask(size_i);
  assign jump_sum = data_pointer_i + {8'h00, acc_i};

  always_comb begin
    nxt_result = 32'h0000_0000;
    nxt_result_we = 1'b0;
    nxt_wdata = 32'h0000_0000;
    nxt_addr = 24'h000000;
    nxt_rd = 1'b0;
    nxt_wr = 1'b0;
    nxt_zn_upd = 1'b0;
    nxt_carry = carry_flag_i;
    nxt_carry_upd = 1'b0;
    nxt_err = 1'b0;
    nxt_pc = pc_next_i;
    nxt_pc_load = 1'b0;
    if (op_valid_i) begin
      case (op_i)
        OP_LOGIC_AND: begin
          nxt_result = opa_i & opb_i & mask; // RULE_01
          nxt_result_we = 1'b1;
          nxt_zn_upd = 1'b1;
        end
        OP_LOGIC_OR: begin
          nxt_result = (opa_i | opb_i) & mask; // RULE_01
          nxt_result_we = 1'b1;
          nxt_zn_upd = 1'b1;
        end
        OP_LOGIC_XOR: begin
          nxt_result = (opa_i ^ opb_i) & mask; // RULE_01
          nxt_result_we = 1'b1;
          nxt_zn_upd = 1'b1;
        end
        OP_SHIFT_LEFT_LOGICAL: begin
          nxt_result = {opa_i[30:0], 1'b0} & mask; // RULE_02
          nxt_carry = top_bit(opa_i, size_i); // RULE_23
          nxt_carry_upd = 1'b1;
          nxt_result_we = 1'b1;
          nxt_zn_upd = 1'b1;
        end
        OP_SHIFT_RIGHT_LOGIC, OP_SHIFT_RIGHT_ARITH: begin
          nxt_result = (opa_i & mask) >> 1; // RULE_03
          if (op_i == OP_SHIFT_RIGHT_ARITH && top_bit(opa_i, size_i)) begin
            nxt_result = nxt_result | (mask & ~(mask >> 1)); // RULE_03
          end
          nxt_carry = opa_i[0]; // RULE_23
          nxt_carry_upd = 1'b1;
          nxt_result_we = 1'b1;
          nxt_zn_upd = 1'b1;
        end
        OP_MOVE: begin
          // Register targets take the result; memory targets get data and address but no write strobe.
          nxt_result = opb_i & mask; // RULE_04
          nxt_result_we = 1'b1;
          nxt_wdata = opb_i & mask;
          nxt_addr = opa_i[23:0];
        end
        OP_EXT_MOVE_READ: begin
          nxt_addr = {dpx_ff, data_pointer_i}; // RULE_05
          nxt_rd = 1'b1;
        end
        OP_EXT_MOVE_WRITE: begin
          nxt_addr = {dpx_ff, data_pointer_i}; // RULE_05
          nxt_wdata = {24'h000000, acc_i};
          nxt_wr = 1'b1;
        end
        OP_CODE_MOVE: begin
          nxt_addr = {`LMB_CODE_REGION, opb_i[15:0]}; // RULE_06
          nxt_rd = 1'b1;
        end
        OP_SIGN_EXTEND_MOVE: begin
          nxt_result = {16'h0000, {8{opb_i[7]}}, opb_i[7:0]}; // RULE_07
          nxt_result_we = 1'b1;
        end
        OP_ZERO_EXTEND_MOVE: begin
          nxt_result = {24'h000000, opb_i[7:0]}; // RULE_07
          nxt_result_we = 1'b1;
        end
        OP_HIGH_WORD_MOVE: begin
          nxt_result = {opb_i[15:0], opa_i[15:0]}; // RULE_08
          nxt_result_we = 1'b1;
        end
        OP_NIBBLE_EXCHANGE: begin
          nxt_result = {24'h000000, acc_i[7:4], opb_i[3:0]}; // RULE_09
          nxt_result_we = 1'b1;
          nxt_wdata = {24'h000000, opb_i[7:4], acc_i[3:0]}; // RULE_09
          nxt_addr = {16'h0000, opa_i[7:0]};
          nxt_wr = 1'b1;
        end
        OP_PUSH: begin
          nxt_addr = push_addr; // RULE_10
          nxt_wdata = opb_i & mask;
          nxt_wr = 1'b1;
        end
        OP_POP: begin
          // A dword pop is not an operation of this core; it is refused.
          if (size_i == SZ_DWORD) begin
            nxt_err = 1'b1;
          end else begin
            nxt_addr = pop_addr; // RULE_10
            nxt_rd = 1'b1;
          end
        end
        OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_COMPLEMENT, OP_CARRY_TO_BIT: begin
          if (!loc_ok) begin
            nxt_err = 1'b1;
          end else begin
            nxt_addr = {16'h0000, loc_byte};
            nxt_wr = 1'b1;
            case (op_i)
              OP_BIT_SET: nxt_wdata[7:0] = bit_byte_i | bit_mask; // RULE_11
              OP_BIT_CLEAR: nxt_wdata[7:0] = bit_byte_i & ~bit_mask; // RULE_11
              OP_BIT_COMPLEMENT: nxt_wdata[7:0] = bit_byte_i ^ bit_mask;
              default: begin
                nxt_wdata[7:0] = carry_flag_i ? (bit_byte_i | bit_mask) :
                  (bit_byte_i & ~bit_mask); // RULE_13
              end
            endcase
          end
        end
        OP_BIT_AND, OP_BIT_OR, OP_BIT_TO_CARRY: begin
          if (!loc_ok) begin
            nxt_err = 1'b1;
          end else begin
            nxt_carry_upd = 1'b1;
            case (op_i) // RULE_12
              OP_BIT_AND: nxt_carry = carry_flag_i & (cur_bit ^ bit_inv_i);
              OP_BIT_OR: nxt_carry = carry_flag_i | (cur_bit ^ bit_inv_i);
              default: nxt_carry = cur_bit; // RULE_13
            endcase
          end
        end
        OP_JUMP_REL: begin
          nxt_pc = pc_next_i + {{16{opb_i[7]}}, opb_i[7:0]}; // RULE_17
          nxt_pc_load = 1'b1;
        end
        OP_JUMP_11: begin
          nxt_pc = {pc_next_i[23:11], opb_i[10:0]}; // RULE_18
          nxt_pc_load = 1'b1;
        end
        OP_JUMP_16: begin
          nxt_pc = {pc_next_i[23:16], opb_i[15:0]}; // RULE_19
          nxt_pc_load = 1'b1;
        end
        OP_JUMP_24: begin
          nxt_pc = opb_i[23:0]; // RULE_20
          nxt_pc_load = 1'b1;
        end
        OP_JUMP_WORD_REG: begin
          nxt_pc = {pc_next_i[23:16], opa_i[15:0]}; // RULE_21
          nxt_pc_load = 1'b1;
        end
        OP_JUMP_ACC_POINTER: begin
          nxt_pc = {`LMB_CODE_REGION, jump_sum}; // RULE_22
          nxt_pc_load = 1'b1;
        end
        default: begin
          nxt_pc_load = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      result_o <= 32'h0000_0000;
      result_we_o <= 1'b0;
      mem_wdata_o <= 32'h0000_0000;
      mem_addr_o <= 24'h000000;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_size_o <= SZ_BYTE;
      bit_sfr_o <= 1'b0;
    end else begin
      result_o <= nxt_result;
      result_we_o <= nxt_result_we;
      mem_wdata_o <= nxt_wdata;
      mem_addr_o <= nxt_addr;
      mem_rd_o <= nxt_rd;
      mem_wr_o <= nxt_wr;
      mem_size_o <= size_i;
      bit_sfr_o <= loc_sfr;
    end
  end

  // Flags hold their last value between updates so software can read them.
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      zero_flag_o <= 1'b0;
      neg_flag_o <= 1'b0;
      zn_upd_o <= 1'b0;
      carry_flag_o <= 1'b0;
      carry_upd_o <= 1'b0;
      op_err_o <= 1'b0;
    end else begin
      zn_upd_o <= nxt_zn_upd;
      carry_upd_o <= nxt_carry_upd;
      if (nxt_zn_upd) begin
        zero_flag_o <= (nxt_result == 32'h0000_0000); // RULE_24
        neg_flag_o <= top_bit(nxt_result, size_i); // RULE_24
      end
      if (nxt_carry_upd) begin
        carry_flag_o <= nxt_carry;
      end
      if (op_valid_i) begin
        op_err_o <= nxt_err;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pc_o <= 24'h000000; // RULE_16
      pc_load_o <= 1'b0;
    end else begin
      pc_o <= nxt_pc;
      pc_load_o <= nxt_pc_load;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_sync_ff);

  shift_left_a: assert property ( // RULE_02
    (op_valid_i && op_i == OP_SHIFT_LEFT_LOGICAL && size_i == SZ_BYTE) |=>
    (result_o[7:0] == {$past(opa_i[6:0]), 1'b0} &&
     carry_flag_o == $past(opa_i[7])))
    else $error("Byte left shift result or carry is wrong.");

  shift_arith_a: assert property ( // RULE_03
    (op_valid_i && op_i == OP_SHIFT_RIGHT_ARITH && size_i == SZ_WORD) |=>
    (result_o[15:0] == {$past(opa_i[15]), $past(opa_i[15:1])} &&
     carry_flag_o == $past(opa_i[0])))
    else $error("Word arithmetic right shift is wrong.");

  logic_flags_a: assert property ( // RULE_24
    (op_valid_i && op_i == OP_LOGIC_XOR && opa_i == opb_i) |=>
    (zn_upd_o && zero_flag_o && !neg_flag_o))
    else $error("Zero flag not set after a zero logic result.");

  ext_region_a: assert property ( // RULE_05
    (op_valid_i && op_i == OP_EXT_MOVE_READ) |=>
    (mem_rd_o && mem_addr_o[23:16] == $past(dpx_ff) &&
     mem_addr_o[15:0] == $past(data_pointer_i)))
    else $error("External move region is wrong.");

  sign_ext_a: assert property ( // RULE_07
    (op_valid_i && op_i == OP_SIGN_EXTEND_MOVE) |=>
    (result_o[15:8] == {8{result_o[7]}} && result_we_o))
    else $error("Sign extension high byte is wrong.");

  jump_block_a: assert property ( // RULE_18
    (op_valid_i && op_i == OP_JUMP_11) |=>
    (pc_load_o && pc_o[23:11] == $past(pc_next_i[23:11]) &&
     pc_o[10:0] == $past(opb_i[10:0])))
    else $error("Eleven bit target left its block.");

  jump_index_a: assert property ( // RULE_22
    (op_valid_i && op_i == OP_JUMP_ACC_POINTER) |=>
    (pc_o[23:16] == `LMB_CODE_REGION && pc_load_o))
    else $error("Indexed jump not in code region.");

  legacy_range_a: assert property ( // RULE_14
    (op_valid_i && op_i == OP_BIT_SET && bit_legacy_i && !bit_flat_i &&
     !bit_sfr_i && bit_reg_i == 8'h30) |=> (op_err_o && !mem_wr_o))
    else $error("Legacy bit reached RAM beyond its range.");

  stack_order_a: assert property ( // RULE_10
    (op_valid_i && op_i == OP_PUSH && size_i == SZ_WORD && !reg_wr_i)
    ##1 (op_valid_i && op_i == OP_POP && size_i == SZ_WORD && !reg_wr_i)
    |=> (mem_addr_o == $past(mem_addr_o)))
    else $error("Pop did not return the last pushed word.");

  push_pop_c: cover property (
    (op_valid_i && op_i == OP_PUSH) ##1 (op_valid_i && op_i == OP_POP));
  bit_carry_c: cover property (
    op_valid_i && op_i == OP_BIT_AND && bit_inv_i && loc_ok);
  rel_back_c: cover property (
    op_valid_i && op_i == OP_JUMP_REL && opb_i[7]);

endmodule // lmb_exec

// ==== core/lmb_params.svh ====
// Constants for the logic, move, bit and branch execution unit.
`ifndef LMB_PARAMS_SVH
`define LMB_PARAMS_SVH

// ****************************************
// Register port offsets
// ****************************************
`define LMB_REG_DPX_OFF 8'h00
`define LMB_REG_SP_OFF 8'h04
`define LMB_REG_STAT_OFF 8'h08

// ****************************************
// Reset values
// ****************************************
`define LMB_DPX_RST 8'h01
`define LMB_SP_RST 24'h000007

// ****************************************
// Status field positions
// ****************************************
`define LMB_STAT_Z_BIT 0
`define LMB_STAT_N_BIT 1
`define LMB_STAT_C_BIT 2
`define LMB_STAT_ERR_BIT 3

// ****************************************
// Address ranges
// ****************************************
`define LMB_CODE_REGION 8'hFF
`define LMB_RAM_BIT_LO 8'h20
`define LMB_RAM_BIT_HI_EXT 8'h7F
`define LMB_RAM_BIT_HI_LEG 8'h2F
`define LMB_SFR_BASE 8'h80

`endif

// ==== core/lmb_pkg.sv ====
// Types shared by the logic, move, bit and branch execution unit.
package lmb_pkg;

  typedef enum logic [29:0] {
    OP_LOGIC_AND          = 30'h0000_0001,
    OP_LOGIC_OR           = 30'h0000_0002,
    OP_LOGIC_XOR          = 30'h0000_0004,
    OP_SHIFT_LEFT_LOGICAL = 30'h0000_0008,
    OP_SHIFT_RIGHT_LOGIC  = 30'h0000_0010,
    OP_SHIFT_RIGHT_ARITH  = 30'h0000_0020,
    OP_MOVE               = 30'h0000_0040,
    OP_EXT_MOVE_READ      = 30'h0000_0080,
    OP_EXT_MOVE_WRITE     = 30'h0000_0100,
    OP_CODE_MOVE          = 30'h0000_0200,
    OP_SIGN_EXTEND_MOVE   = 30'h0000_0400,
    OP_ZERO_EXTEND_MOVE   = 30'h0000_0800,
    OP_HIGH_WORD_MOVE     = 30'h0000_1000,
    OP_NIBBLE_EXCHANGE    = 30'h0000_2000,
    OP_PUSH               = 30'h0000_4000,
    OP_POP                = 30'h0000_8000,
    OP_BIT_SET            = 30'h0001_0000,
    OP_BIT_CLEAR          = 30'h0002_0000,
    OP_BIT_COMPLEMENT     = 30'h0004_0000,
    OP_BIT_AND            = 30'h0008_0000,
    OP_BIT_OR             = 30'h0010_0000,
    OP_BIT_TO_CARRY       = 30'h0020_0000,
    OP_CARRY_TO_BIT       = 30'h0040_0000,
    OP_JUMP_REL           = 30'h0080_0000,
    OP_JUMP_11            = 30'h0100_0000,
    OP_JUMP_16            = 30'h0200_0000,
    OP_JUMP_24            = 30'h0400_0000,
    OP_JUMP_WORD_REG      = 30'h0800_0000,
    OP_JUMP_ACC_POINTER   = 30'h1000_0000,
    OP_NONE               = 30'h2000_0000
  } lmb_op_t;

  typedef enum logic [1:0] {
    SZ_BYTE  = 2'h0,
    SZ_WORD  = 2'h1,
    SZ_DWORD = 2'h2
  } lmb_size_t;

endpackage

// ==== verification/lmb_exec_bench.sv ====
// Self-checking bench for the logic, move, bit and branch unit.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module lmb_exec_bench;
  import lmb_pkg::*;
  logic clk_sys_i, rst_n_i, op_valid_i, carry_flag_i, bit_legacy_i;
  logic bit_flat_i, bit_sfr_i, bit_inv_i, reg_wr_i, reg_rd_i;
  lmb_op_t op_i;
  lmb_size_t size_i;
  logic [31:0] opa_i, opb_i, reg_wdata_i, reg_rdata_o, result_o, mem_wdata_o;
  logic [23:0] pc_next_i, mem_addr_o, pc_o, pn;
  logic [15:0] data_pointer_i, dp;
  logic [7:0] acc_i, legacy_bit_operand_i, bit_reg_i, bit_byte_i, reg_addr_i;
  logic [7:0] ac, k;
  logic [2:0] bit_pos_i;
  logic [1:0] mem_size_o;
  logic result_we_o, mem_rd_o, mem_wr_o, bit_sfr_o, zero_flag_o, neg_flag_o;
  logic zn_upd_o, carry_flag_o, carry_upd_o, op_err_o, pc_load_o, cy, e;
  int err_count, compares, i, w;
  integer seed;
  logic [31:0] a, b, r, m;
  lmb_size_t s;

  lmb_exec i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .size_i(size_i), .opa_i(opa_i),
    .opb_i(opb_i), .acc_i(acc_i), .data_pointer_i(data_pointer_i),
    .carry_flag_i(carry_flag_i), .pc_next_i(pc_next_i),
    .bit_legacy_i(bit_legacy_i), .bit_flat_i(bit_flat_i),
    .legacy_bit_operand_i(legacy_bit_operand_i), .bit_sfr_i(bit_sfr_i),
    .bit_reg_i(bit_reg_i), .bit_pos_i(bit_pos_i), .bit_byte_i(bit_byte_i),
    .bit_inv_i(bit_inv_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .result_o(result_o),
    .result_we_o(result_we_o), .mem_wdata_o(mem_wdata_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_size_o(mem_size_o), .bit_sfr_o(bit_sfr_o),
    .zero_flag_o(zero_flag_o), .neg_flag_o(neg_flag_o),
    .zn_upd_o(zn_upd_o), .carry_flag_o(carry_flag_o),
    .carry_upd_o(carry_upd_o), .op_err_o(op_err_o), .pc_o(pc_o),
    .pc_load_o(pc_load_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // ********************
  // Bus tasks
  // ********************
  // Results are registered, so they are read 1 ns after the edge that takes the op.
  task automatic op(lmb_op_t o, lmb_size_t z, logic [31:0] x, logic [31:0] y);
    op_valid_i <= 1'b1;
    op_i <= o;
    size_i <= z;
    opa_i <= x;
    opb_i <= y;
    pc_next_i <= pn;
    acc_i <= ac;
    data_pointer_i <= dp;
    carry_flag_i <= cy;
    @(posedge clk_sys_i);
    op_valid_i <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [7:0] ad, logic [31:0] x);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("reg_rdata_o", x, reg_rdata_o)
  endtask

  task automatic wr(logic [7:0] ad, logic [31:0] x);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= x;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("Compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    wrap_up();
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    seed = 32'hD569;
    {op_valid_i, carry_flag_i, bit_legacy_i, bit_flat_i, bit_sfr_i} = '0;
    {bit_inv_i, reg_wr_i, reg_rd_i, rst_n_i, cy} = '0;
    {op_i, size_i} = {OP_NONE, SZ_BYTE};
    {opa_i, opb_i, reg_wdata_i, pc_next_i, data_pointer_i} = '0;
    {acc_i, legacy_bit_operand_i, bit_reg_i, bit_byte_i, reg_addr_i} = '0;
    {bit_pos_i, pn, ac, dp} = '0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h7);
    wr(8'h08, 32'hF);
    wr(8'h04, 32'h100);
    rd(8'h04, 32'h100);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    for (i = 0; i < 12; i++) begin
      a = $random(seed);
      b = (i % 6 == 0) ? 32'h0 : $random(seed);
      s = lmb_size_t'(i % 2);
      m = s == SZ_BYTE ? 32'hFF : 32'hFFFF;
      op(lmb_op_t'(30'h1 << (i % 3)), s, a, b);
      r = (i % 3 == 0 ? a & b : i % 3 == 1 ? a | b : a ^ b) & m;
      `CHK("result_o", r, result_o)
      `CHK("zero_flag_o", r == 0, zero_flag_o)
      `CHK("neg_flag_o", r[s == SZ_BYTE ? 7 : 15], neg_flag_o)
      a = $random(seed);
      w = s == SZ_BYTE ? 8 : 16;
      op(lmb_op_t'(30'h8 << (i % 3)), s, a, 32'h0);
      r = i % 3 == 0 ? a << 1 : (a & m) >> 1;
      if (i % 3 == 2) r[w - 1] = a[w - 1];
      `CHK("result_o", r & m, result_o)
      `CHK("carry_flag_o", i % 3 ? a[0] : a[w - 1], carry_flag_o)
      b[7] = i[1];
      op(i % 2 ? OP_ZERO_EXTEND_MOVE : OP_SIGN_EXTEND_MOVE, SZ_WORD, a, b);
      r = {16'h0, (i % 2) ? 8'h0 : {8{b[7]}}, b[7:0]};
      `CHK("result_o", r, result_o)
      op(OP_HIGH_WORD_MOVE, SZ_DWORD, a, b);
      `CHK("result_o", {b[15:0], a[15:0]}, result_o)
      {pn, ac, dp} = 48'({$random(seed), $random(seed)});
      op(lmb_op_t'(30'h80_0000 << (i % 6)), SZ_WORD, a, b);
      case (i % 6)
        0: r = pn + {{16{b[7]}}, b[7:0]};
        1: r = {pn[23:11], b[10:0]};
        2: r = {pn[23:16], b[15:0]};
        3: r = b[23:0];
        4: r = {pn[23:16], a[15:0]};
        default: r = {8'hFF, 16'(ac + dp)};
      endcase
      `CHK("pc_o", r[23:0], pc_o)
      `CHK("pc_load_o", 1'b1, pc_load_o)
    end
    for (i = 0; i < 14; i++) begin
      b = $random(seed);
      cy = b[8];
      if (i % 7 != 3 && i % 7 != 4) b[9] = 1'b0;
      k = 8'h1 << b[18:16];
      e = b[b[18:16]];
      @(posedge clk_sys_i);
      {bit_legacy_i, bit_flat_i, bit_sfr_i, bit_inv_i} <= {3'b0, b[9]};
      bit_reg_i <= {2'b01, b[15:10]};
      bit_pos_i <= b[18:16];
      bit_byte_i <= b[7:0];
      op(lmb_op_t'(30'h1_0000 << (i % 7)), SZ_BYTE, 32'h0, 32'h0);
      case (i % 7)
        0: `CHK("mem_wdata_o", b[7:0] | k, mem_wdata_o[7:0])
        1: `CHK("mem_wdata_o", b[7:0] & ~k, mem_wdata_o[7:0])
        2: `CHK("mem_wdata_o", b[7:0] ^ k, mem_wdata_o[7:0])
        3: `CHK("carry_flag_o", cy & (e ^ b[9]), carry_flag_o)
        4: `CHK("carry_flag_o", cy | (e ^ b[9]), carry_flag_o)
        5: `CHK("carry_flag_o", e, carry_flag_o)
        default: `CHK("mem_wdata_o", b[7:0] & ~k | (cy ? k : 8'h0),
          mem_wdata_o[7:0])
      endcase
    end
    @(posedge clk_sys_i);
    {bit_legacy_i, bit_flat_i, bit_reg_i} <= {2'b10, 8'h30};
    op(OP_BIT_SET, SZ_BYTE, 32'h0, 32'h0);
    `CHK("op_err_o", 1'b1, op_err_o)
    `CHK("mem_wr_o", 1'b0, mem_wr_o)
    @(posedge clk_sys_i);
    {bit_legacy_i, bit_flat_i, legacy_bit_operand_i} <= {2'b11, 8'h8A};
    bit_byte_i <= 8'h11;
    op(OP_BIT_SET, SZ_BYTE, 32'h0, 32'h0);
    `CHK("mem_addr_o", 8'h88, mem_addr_o[7:0])
    `CHK("bit_sfr_o", 1'b1, bit_sfr_o)
    `CHK("mem_wdata_o", 8'h15, mem_wdata_o[7:0])
    @(posedge clk_sys_i);
    bit_legacy_i <= 1'b0;
    op(OP_BIT_SET, SZ_BYTE, 32'h0, 32'h0);
    `CHK("op_err_o", 1'b1, op_err_o)
    {ac, dp} = 24'hA51234;
    op(OP_NIBBLE_EXCHANGE, SZ_BYTE, 32'h30, 32'h3C);
    `CHK("result_o", 32'hAC, result_o)
    `CHK("mem_wdata_o", 32'h35, mem_wdata_o)
    op(OP_EXT_MOVE_READ, SZ_BYTE, 32'h0, 32'h0);
    `CHK("mem_addr_o", 24'h011234, mem_addr_o)
    `CHK("mem_rd_o", 1'b1, mem_rd_o)
    op(OP_CODE_MOVE, SZ_BYTE, 32'h0, 32'h5678);
    `CHK("mem_addr_o", 24'hFF5678, mem_addr_o)
    op(OP_MOVE, SZ_WORD, 32'h0, 32'hCAFE_BABE);
    `CHK("result_o", 32'hBABE, result_o)
    op(OP_PUSH, SZ_WORD, 32'h0, 32'h0);
    `CHK("mem_addr_o", 24'h101, mem_addr_o)
    op(OP_POP, SZ_WORD, 32'h0, 32'h0);
    `CHK("mem_addr_o", 24'h101, mem_addr_o)
    op(OP_POP, SZ_DWORD, 32'h0, 32'h0);
    `CHK("op_err_o", 1'b1, op_err_o)
    wrap_up();
  end
endmodule // lmb_exec_bench
